/* rtl/flash_ctl_defines.svh */
// Register offsets, field positions, reset values and timing counts of the flash controller.
`ifndef FLASH_CTL_DEFINES_SVH
`define FLASH_CTL_DEFINES_SVH

`define PSC_OFS             8'h00
`define FMC_OFS             8'h04
`define STAT_OFS            8'h08

`define PSC_REDIRECT_BIT    0
`define PSC_ERASE_BIT       1
`define PSC_SCRATCH_BIT     2
`define FMC_SWWE_BIT        0
`define STAT_BUSY_BIT       0
`define STAT_IGNORED_BIT    1

`define PSC_RESET           3'h0
`define FMC_RESET           1'h0

`define MAIN_PAGE_BYTES     10'h0200
`define SCRATCH_BYTES       10'h0080
`define SCRATCH_LIMIT       16'h0080
`define IRQ_LINES           8

`define CLK_MHZ             50
`define WRITE_TIME_NS       40000
`define ERASE_TIME_NS       10000000
`define WRITE_CYCLES        ((`WRITE_TIME_NS * `CLK_MHZ + 999) / 1000)
`define ERASE_CYCLES        ((`ERASE_TIME_NS * `CLK_MHZ + 999) / 1000)

`endif

/* rtl/flash_ctl_pkg.sv */
// Types shared by the flash controller files.
package flash_ctl_pkg;

  typedef enum {ST_IDLE, ST_PROGRAM, ST_ERASE} flash_state_t;

  typedef enum logic {SRC_CORE, SRC_DEBUG} op_source_t;

endpackage : flash_ctl_pkg

/* rtl/flash_bank.sv */
// One flash byte array with an and-programming and erase-to-ones write port.
`timescale 1ns/1ps
module flash_bank #(
  parameter int AW = 9
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic          erase_mode,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);

  logic [7:0] mem [0:(1<<AW)-1];
  wire  [7:0] old_val = mem[waddr];
  wire  [7:0] new_val = erase_mode ? 8'hFF : (old_val & wdata);

  // Contents survive reset on purpose: this is non-volatile storage.
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= new_val;
    end
  end

  assign rdata = mem[raddr];

  ////////////////////////////////////////////////////////////////////////////
  wire [7:0] cur_val = mem[waddr];

  a_program_ands_bits: assert property (@(posedge clk)
    ce && we && !erase_mode ##1 $stable(waddr) |-> cur_val == ($past(old_val) & $past(wdata)))
    else $error("program did not and old and new data");

  a_erase_sets_ones: assert property (@(posedge clk)
    ce && we && erase_mode ##1 $stable(waddr) |-> cur_val == 8'hFF)
    else $error("erased byte is not all ones");

endmodule : flash_bank

/* rtl/flash_program_erase_control.sv */
// Flash program and erase sequencer with write redirection, stall and interrupt hold.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "flash_ctl_defines.svh"

// Operation
// - Programming only clears bits; stored byte is old AND new.
// - Erase clears a whole page to all ones: 512 bytes in main flash, 128 in the scratchpad.
// - With write redirect set, data writes go to flash, not external RAM.
// - Write redirect stays set until software clears it.
// - Data reads always go to external RAM.
// - Flash contents are read over the code read path.
// - Software writes and erases act only while software write enable is set.
// - Erase enable plus redirect makes any data write erase its page.
// - Without erase enable a redirected write programs the byte.
// - Each program operation writes one byte, from core or debug port.
// - Write and erase are timed internally to completion.
// - Core is stalled from start to end of each operation.
// - Interrupts during an operation are held, then released together.
// - A 128-byte scratchpad overlays 0x00 to 0x7F when selected.
// - Instruction fetch never reads the scratchpad.
module flash_program_erase_control #(
  parameter int ERASE_CYCLES = `ERASE_CYCLES
) (
  input  wire logic                  CORE_CLK,
  input  wire logic                  RST,
  input  wire logic                  CE,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [7:0]            PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire logic                  XW_REQ,
  input  wire logic [15:0]           XW_ADDR,
  input  wire logic [7:0]            XW_DATA,
  input  wire logic                  XR_REQ,
  input  wire logic [15:0]           XR_ADDR,
  output logic                       EXTERNAL_DATA_RAM_WE,
  output logic      [15:0]           EXTERNAL_DATA_RAM_WADDR,
  output logic      [7:0]            EXTERNAL_DATA_RAM_WDATA,
  output logic                       EXTERNAL_DATA_RAM_RE,
  output logic      [15:0]           EXTERNAL_DATA_RAM_RADDR,
  input  wire logic                  CODE_RD,
  input  wire logic                  CODE_FETCH,
  input  wire logic [15:0]           CODE_ADDR,
  output logic      [7:0]            CODE_RDATA,
  output logic                       CODE_RVALID,
  input  wire logic                  DBG_REQ,
  input  wire logic                  DBG_ERASE,
  input  wire logic [15:0]           DBG_ADDR,
  input  wire logic [7:0]            DBG_DATA,
  output logic                       DBG_DONE,
  output logic                       CPU_STALL,
  input  wire logic [`IRQ_LINES-1:0] IRQ_REQ,
  output logic      [`IRQ_LINES-1:0] IRQ_OUT
);

  localparam logic [19:0] WR_LAST = 20'(`WRITE_CYCLES - 1);
  localparam logic [19:0] ER_LAST = 20'(ERASE_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and operation state.
  logic                          redirect_r;
  logic                          erase_en_r;
  logic                          scratch_sel_r;
  logic                          swwe_r;
  logic                          ignored_r;
  flash_ctl_pkg::flash_state_t   state_r;
  flash_ctl_pkg::flash_state_t   state_nxt;
  flash_ctl_pkg::op_source_t     src_r;
  logic                          op_scratch_r;
  logic [15:0]                   op_addr_r;
  logic [7:0]                    op_data_r;
  logic [19:0]                   cnt_r;
  logic [9:0]                    walk_r;
  logic [`IRQ_LINES-1:0]         held_r;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.
  wire apb_acc   = PSEL && PENABLE;
  wire apb_done  = apb_acc && PREADY;
  wire hit_psc   = PADDR == `PSC_OFS;
  wire hit_fmc   = PADDR == `FMC_OFS;
  wire hit_stat  = PADDR == `STAT_OFS;
  wire hit_any   = hit_psc || hit_fmc || hit_stat;
  wire psc_wr    = apb_done && PWRITE && hit_psc;
  wire fmc_wr    = apb_done && PWRITE && hit_fmc;
  wire stat_wr   = apb_done && PWRITE && hit_stat;
  wire idle      = state_r == flash_ctl_pkg::ST_IDLE;

  wire [31:0] psc_val  = {29'h0000_0000, scratch_sel_r, erase_en_r, redirect_r};
  wire [31:0] fmc_val  = {31'h0000_0000, swwe_r};
  wire [31:0] stat_val = {30'h0000_0000, ignored_r, !idle};
  wire [31:0] rd_mux   = hit_psc ? psc_val : hit_fmc ? fmc_val : hit_stat ? stat_val
                         : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Request steering.
  wire redir_wr    = XW_REQ && redirect_r;
  wire start_core  = redir_wr && swwe_r && idle;
  wire ignore_core = redir_wr && !swwe_r;
  wire start_dbg   = DBG_REQ && idle && !start_core;
  wire start_any   = start_core || start_dbg;
  wire start_erase = start_core ? erase_en_r : DBG_ERASE;
  wire [15:0] start_addr = start_core ? XW_ADDR : DBG_ADDR;
  wire start_scr   = start_core && scratch_sel_r && (XW_ADDR < `SCRATCH_LIMIT);

  // Erase walks the page one byte per cycle while the timer runs.
  wire [9:0]  page_len   = op_scratch_r ? `SCRATCH_BYTES : `MAIN_PAGE_BYTES;
  wire        walking    = walk_r < page_len;
  wire        prog_first = (state_r == flash_ctl_pkg::ST_PROGRAM) && (cnt_r == 20'h0_0000);
  wire        erase_wr   = (state_r == flash_ctl_pkg::ST_ERASE) && walking;
  wire        bank_we    = prog_first || erase_wr;
  wire [15:0] main_waddr = erase_wr ? {op_addr_r[15:9], walk_r[8:0]} : op_addr_r;
  wire [6:0]  scr_waddr  = erase_wr ? walk_r[6:0] : op_addr_r[6:0];
  wire        prog_end   = (state_r == flash_ctl_pkg::ST_PROGRAM) && (cnt_r >= WR_LAST);
  wire        erase_end  = (state_r == flash_ctl_pkg::ST_ERASE) && (cnt_r >= ER_LAST)
                           && !walking;
  wire        op_end     = prog_end || erase_end;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      flash_ctl_pkg::ST_IDLE: begin
        if (start_any) begin
          state_nxt = start_erase ? flash_ctl_pkg::ST_ERASE : flash_ctl_pkg::ST_PROGRAM;
        end
      end
      flash_ctl_pkg::ST_PROGRAM,
      flash_ctl_pkg::ST_ERASE: begin
        if (op_end) begin
          state_nxt = flash_ctl_pkg::ST_IDLE;
        end
      end
      default: state_nxt = flash_ctl_pkg::ST_IDLE;
    endcase
  end

  wire stall_nxt = state_nxt != flash_ctl_pkg::ST_IDLE;

  // Code reads pick the scratchpad only for data reads, never for fetches.
  wire [7:0] main_rdata;
  wire [7:0] scr_rdata;
  wire       code_scr = scratch_sel_r && !CODE_FETCH && (CODE_ADDR < `SCRATCH_LIMIT);
  wire [7:0] code_mux = code_scr ? scr_rdata : main_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Flash arrays.
  flash_bank #(.AW(16)) u_main (
    .clk        (CORE_CLK),
    .ce         (CE),
    .we         (bank_we && !op_scratch_r),
    .erase_mode (erase_wr),
    .waddr      (main_waddr),
    .wdata      (op_data_r),
    .raddr      (CODE_ADDR),
    .rdata      (main_rdata)
  );

  flash_bank #(.AW(7)) u_scratch (
    .clk        (CORE_CLK),
    .ce         (CE),
    .we         (bank_we && op_scratch_r),
    .erase_mode (erase_wr),
    .waddr      (scr_waddr),
    .wdata      (op_data_r),
    .raddr      (CODE_ADDR[6:0]),
    .rdata      (scr_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, then the answer stands for one cycle.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY  <= apb_acc && !PREADY;
      PRDATA  <= (apb_acc && !PREADY && !PWRITE) ? rd_mux : 32'h0000_0000;
      PSLVERR <= apb_acc && !PREADY && !hit_any;
    end
  end

  // Only a software write moves the redirect bit; no flash event touches it.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      {scratch_sel_r, erase_en_r, redirect_r} <= `PSC_RESET;
      swwe_r    <= `FMC_RESET;
      ignored_r <= 1'b0;
    end else if (CE) begin
      if (psc_wr) begin
        redirect_r    <= PWDATA[`PSC_REDIRECT_BIT];
        erase_en_r    <= PWDATA[`PSC_ERASE_BIT];
        scratch_sel_r <= PWDATA[`PSC_SCRATCH_BIT];
      end
      if (fmc_wr) begin
        swwe_r <= PWDATA[`FMC_SWWE_BIT];
      end
      // A new ignored write in the clearing cycle keeps the flag set.
      ignored_r <= ignore_core || (ignored_r && !(stat_wr && PWDATA[`STAT_IGNORED_BIT]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation sequencer.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_r      <= flash_ctl_pkg::ST_IDLE;
      src_r        <= flash_ctl_pkg::SRC_CORE;
      op_scratch_r <= 1'b0;
      op_addr_r    <= 16'h0000;
      op_data_r    <= 8'h00;
      cnt_r        <= 20'h0_0000;
      walk_r       <= 10'h000;
      DBG_DONE     <= 1'b0;
    end else if (CE) begin
      state_r  <= state_nxt;
      DBG_DONE <= op_end && (src_r == flash_ctl_pkg::SRC_DEBUG);
      if (start_any) begin
        src_r        <= start_core ? flash_ctl_pkg::SRC_CORE : flash_ctl_pkg::SRC_DEBUG;
        op_scratch_r <= start_scr;
        op_addr_r    <= start_addr;
        op_data_r    <= start_core ? XW_DATA : DBG_DATA;
        cnt_r        <= 20'h0_0000;
        walk_r       <= 10'h000;
      end else if (!idle) begin
        cnt_r  <= cnt_r + 20'h0_0001;
        walk_r <= walking ? walk_r + 10'h001 : walk_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core side: stall, interrupt hold, external RAM and code reads.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      CPU_STALL   <= 1'b0;
      held_r      <= '0;
      IRQ_OUT     <= '0;
      EXTERNAL_DATA_RAM_WE     <= 1'b0;
      EXTERNAL_DATA_RAM_WADDR  <= 16'h0000;
      EXTERNAL_DATA_RAM_WDATA  <= 8'h00;
      EXTERNAL_DATA_RAM_RE     <= 1'b0;
      EXTERNAL_DATA_RAM_RADDR  <= 16'h0000;
      CODE_RDATA  <= 8'h00;
      CODE_RVALID <= 1'b0;
    end else if (CE) begin
      CPU_STALL   <= stall_nxt;
      held_r      <= stall_nxt ? (held_r | IRQ_REQ) : '0;
      IRQ_OUT     <= stall_nxt ? '0 : (held_r | IRQ_REQ);
      EXTERNAL_DATA_RAM_WE     <= XW_REQ && !redirect_r;
      EXTERNAL_DATA_RAM_WADDR  <= XW_ADDR;
      EXTERNAL_DATA_RAM_WDATA  <= XW_DATA;
      EXTERNAL_DATA_RAM_RE     <= XR_REQ;
      EXTERNAL_DATA_RAM_RADDR  <= XR_ADDR;
      CODE_RVALID <= CODE_RD;
      CODE_RDATA  <= code_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  a_read_to_ram: assert property (
    CE && XR_REQ |=> EXTERNAL_DATA_RAM_RE && EXTERNAL_DATA_RAM_RADDR == $past(XR_ADDR))
    else $error("data read not sent to external RAM");

  a_redirect_no_ram: assert property (
    CE && XW_REQ |=> EXTERNAL_DATA_RAM_WE == !$past(redirect_r))
    else $error("data write steered the wrong way");

  a_redirect_sticky: assert property (
    redirect_r && !psc_wr |=> redirect_r)
    else $error("redirect bit cleared without a software write");

  a_gate_blocks_op: assert property (
    CE && redir_wr && !swwe_r && idle && !DBG_REQ |=> idle && ignored_r)
    else $error("write acted with software write enable clear");

  a_ignored_no_ram: assert property (
    CE && ignore_core && idle && !DBG_REQ |=> !EXTERNAL_DATA_RAM_WE && !CPU_STALL)
    else $error("ignored write reached RAM or flash");

  a_code_read_answer: assert property (
    CE && CODE_RD |=> CODE_RVALID)
    else $error("code read not answered");

  a_stall_ends_idle: assert property (
    CE && op_end |=> !CPU_STALL && idle)
    else $error("stall outlived the flash operation");

  a_erase_selected: assert property (
    CE && start_core && erase_en_r |=> state_r == flash_ctl_pkg::ST_ERASE && walk_r == 10'h000)
    else $error("erase enable did not start a page erase");

  a_program_selected: assert property (
    CE && start_core && !erase_en_r |=> state_r == flash_ctl_pkg::ST_PROGRAM
      && op_data_r == $past(XW_DATA) && op_addr_r == $past(XW_ADDR))
    else $error("redirected write did not start byte program");

  a_single_byte: assert property (
    state_r == flash_ctl_pkg::ST_PROGRAM && cnt_r != 20'h0_0000 |-> !bank_we)
    else $error("program wrote more than one byte");

  a_write_timed: assert property (
    CE && state_r == flash_ctl_pkg::ST_PROGRAM && cnt_r == WR_LAST |=> idle)
    else $error("write did not end at its timed length");

  a_erase_walk_whole: assert property (
    erase_end |-> walk_r == page_len)
    else $error("erase ended before the whole page was cleared");

  a_stall_covers_op: assert property (
    CE && start_any |=> CPU_STALL && !idle ##0 (CPU_STALL == !idle) [*2])
    else $error("core not stalled during flash operation");

  a_irq_held_busy: assert property (
    CPU_STALL |-> IRQ_OUT == '0)
    else $error("interrupt released during flash operation");

  a_irq_released: assert property (
    CE && CPU_STALL && !stall_nxt && held_r != '0 |=> (IRQ_OUT & $past(held_r)) == $past(held_r))
    else $error("held interrupt lost at operation end");

  a_fetch_main_only: assert property (
    CE && CODE_RD && CODE_FETCH |=> CODE_RVALID && CODE_RDATA == $past(main_rdata))
    else $error("instruction fetch served from scratchpad");

  a_scratch_read: assert property (
    CE && CODE_RD && code_scr |=> CODE_RDATA == $past(scr_rdata))
    else $error("scratchpad read not served");

  c_page_erase: cover property (state_r == flash_ctl_pkg::ST_ERASE && erase_end);
  c_byte_program: cover property (prog_end && src_r == flash_ctl_pkg::SRC_CORE);
  c_debug_program: cover property (DBG_DONE);
  c_irq_held: cover property (CPU_STALL && IRQ_REQ != '0);

endmodule : flash_program_erase_control

/* dv/core_model.sv */
// Processor core stand-in issuing data writes, data reads and code reads.
`timescale 1ns/1ps
module core_model (
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic [7:0]  irq_out,
  input  wire logic [7:0]  code_rdata,
  input  wire logic        code_rvalid,
  output logic             xw_req,
  output logic      [15:0] xw_addr,
  output logic      [7:0]  xw_data,
  output logic             xr_req,
  output logic      [15:0] xr_addr,
  output logic             code_rd,
  output logic             code_fetch,
  output logic      [15:0] code_addr,
  output logic      [7:0]  irq_req
);
  initial begin
    {xw_req, xr_req, code_rd, code_fetch} = 4'h0;
    {xw_addr, xw_data, xr_addr, code_addr, irq_req} = '0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Idle lines show the inverse of the last request, so a late sample is caught.
  task automatic data_write(input logic [15:0] a, input logic [7:0] d, input logic [7:0] irq,
                            output int n, output logic [7:0] im, output logic [7:0] ie);
    n = 0;
    im = 8'h00;
    @(posedge clk);
    xw_req  <= 1'b1;
    xw_addr <= a;
    xw_data <= d;
    @(posedge clk);
    xw_req  <= 1'b0;
    xw_addr <= ~a;
    xw_data <= ~d;
    #1;
    // A stalled core executes nothing, so it only counts and posts one interrupt pulse.
    while (stall === 1'b1 && n < 5000) begin
      n++;
      im = im | irq_out;
      @(posedge clk);
      irq_req <= (n == 1) ? irq : 8'h00;
      #1;
    end
    ie = irq_out;
  endtask : data_write

  task automatic data_read(input logic [15:0] a);
    @(posedge clk);
    xr_req  <= 1'b1;
    xr_addr <= a;
    @(posedge clk);
    xr_req  <= 1'b0;
    xr_addr <= ~a;
    #1;
  endtask : data_read

  task automatic code_read(input logic f, input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    code_rd    <= 1'b1;
    code_fetch <= f;
    code_addr  <= a;
    @(posedge clk);
    code_rd    <= 1'b0;
    code_fetch <= ~f;
    code_addr  <= ~a;
    #1;
    d = (code_rvalid === 1'b1) ? code_rdata : 8'hxx;
  endtask : code_read
endmodule : core_model

/* dv/flash_program_erase_control_tb.sv */
// Self-checking bench for the flash program and erase sequencer.
`timescale 1ns/1ps
`include "flash_ctl_defines.svh"
module flash_program_erase_control_tb;
  localparam int ERASE_CYC = 600;
  localparam int PROG_CYC  = 2000;
  logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr, stall, er;
  logic        xw_req, xr_req, external_data_ram_we, external_data_ram_re, code_rd, code_fetch, code_rvalid;
  logic        dbg_req, dbg_erase, dbg_done;
  logic [7:0]  paddr, xw_data, external_data_ram_wdata, code_rdata, dbg_data, irq_req, irq_out, im, ie, cd;
  logic [15:0] xw_addr, xr_addr, external_data_ram_waddr, external_data_ram_raddr, code_addr, dbg_addr, rd_last;
  logic [23:0] wr_last;
  logic [31:0] pwdata, prdata, rd;
  int          n, wr_seen = 0, rd_seen = 0, done_seen = 0, error_cnt = 0, checks_done = 0;

  flash_program_erase_control #(.ERASE_CYCLES(ERASE_CYC)) flash_program_erase_control_i (
    .CORE_CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .XW_REQ(xw_req), .XW_ADDR(xw_addr), .XW_DATA(xw_data), .XR_REQ(xr_req),
    .XR_ADDR(xr_addr), .EXTERNAL_DATA_RAM_WE(external_data_ram_we), .EXTERNAL_DATA_RAM_WADDR(external_data_ram_waddr), .EXTERNAL_DATA_RAM_WDATA(external_data_ram_wdata),
    .EXTERNAL_DATA_RAM_RE(external_data_ram_re), .EXTERNAL_DATA_RAM_RADDR(external_data_ram_raddr), .CODE_RD(code_rd), .CODE_FETCH(code_fetch),
    .CODE_ADDR(code_addr), .CODE_RDATA(code_rdata), .CODE_RVALID(code_rvalid),
    .DBG_REQ(dbg_req), .DBG_ERASE(dbg_erase), .DBG_ADDR(dbg_addr), .DBG_DATA(dbg_data),
    .DBG_DONE(dbg_done), .CPU_STALL(stall), .IRQ_REQ(irq_req), .IRQ_OUT(irq_out));

  core_model core_model_i (
    .clk(clk), .stall(stall), .irq_out(irq_out), .code_rdata(code_rdata),
    .code_rvalid(code_rvalid), .xw_req(xw_req), .xw_addr(xw_addr), .xw_data(xw_data),
    .xr_req(xr_req), .xr_addr(xr_addr), .code_rd(code_rd), .code_fetch(code_fetch),
    .code_addr(code_addr), .irq_req(irq_req));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (external_data_ram_we === 1'b1) begin
      wr_seen++;
      wr_last = {external_data_ram_waddr, external_data_ram_wdata};
    end
    if (external_data_ram_re === 1'b1) begin
      rd_seen++;
      rd_last = external_data_ram_raddr;
    end
    if (dbg_done === 1'b1) done_seen++;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // The request stands until pready is seen high at a rising edge; the answer is taken there.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    check(32'(pready), 32'h0000_0001, "apb ready");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reg_is(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp, "register");
  endtask : reg_is

  task automatic op(input logic [15:0] a, input logic [7:0] d, input int exp_n);
    core_model_i.data_write(a, d, 8'h00, n, im, ie);
    check(32'(n), 32'(exp_n), "stall length");
  endtask : op

  task automatic flash_is(input logic f, input logic [15:0] a, input logic [7:0] exp);
    core_model_i.code_read(f, a, cd);
    check(32'(cd), 32'(exp), "flash byte");
  endtask : flash_is

  task automatic dbg_op(input logic e, input logic [15:0] a, input logic [7:0] d);
    int k;
    k = done_seen;
    @(posedge clk);
    dbg_req   <= 1'b1;
    dbg_erase <= e;
    dbg_addr  <= a;
    dbg_data  <= d;
    @(posedge clk);
    dbg_req   <= 1'b0;
    dbg_erase <= ~e;
    dbg_addr  <= ~a;
    dbg_data  <= ~d;
    n = 0;
    while (done_seen == k && n < 5000) begin
      @(posedge clk);
      n++;
    end
  endtask : dbg_op

  initial begin
    {rst, ce, psel, penable, pwrite, dbg_req, dbg_erase} = 7'h60;
    {paddr, pwdata, dbg_addr, dbg_data} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reg_is(`PSC_OFS, 32'h0000_0000);
    reg_is(`FMC_OFS, 32'h0000_0000);
    reg_is(`STAT_OFS, 32'h0000_0000);
    apb(1'b1, `PSC_OFS, 32'hFFFF_FFFF);
    reg_is(`PSC_OFS, 32'h0000_0007);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    check(32'(er), 32'h0000_0001, "unmapped error");
    $display("test registers done");
    apb(1'b1, `PSC_OFS, 32'h0000_0000);
    op(16'h1234, 8'h3C, 0);
    core_model_i.data_read(16'h4321);
    reg_is(`PSC_OFS, 32'h0000_0000);
    check(32'(wr_last), 32'h0012_343C, "ram write");
    check(32'(rd_seen), 32'h0000_0001, "ram reads");
    apb(1'b1, `PSC_OFS, 32'h0000_0001);
    op(16'h0300, 8'h00, 0);
    core_model_i.data_read(16'h0300);
    reg_is(`STAT_OFS, 32'h0000_0002);
    apb(1'b1, `STAT_OFS, 32'h0000_0002);
    reg_is(`STAT_OFS, 32'h0000_0000);
    check(32'(rd_last), 32'h0000_0300, "ram read addr");
    // With the clock enable low a read request must leave no trace.
    @(posedge clk);
    ce <= 1'b0;
    core_model_i.data_read(16'h0055);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    check(32'(rd_seen), 32'h0000_0002, "frozen read");
    $display("test steering done");
    // Erase, clear erase enable, then program: the page sequence software is told to use.
    apb(1'b1, `FMC_OFS, 32'h0000_0001);
    apb(1'b1, `PSC_OFS, 32'h0000_0003);
    op(16'h05FF, 8'h00, ERASE_CYC);
    apb(1'b1, `PSC_OFS, 32'h0000_0001);
    op(16'h0400, 8'h11, PROG_CYC);
    apb(1'b1, `PSC_OFS, 32'h0000_0003);
    op(16'h03FF, 8'h00, ERASE_CYC);
    reg_is(`PSC_OFS, 32'h0000_0003);
    flash_is(1'b0, 16'h0200, 8'hFF);
    flash_is(1'b0, 16'h03FF, 8'hFF);
    flash_is(1'b0, 16'h0400, 8'h11);
    flash_is(1'b0, 16'h05FF, 8'hFF);
    $display("test erase done");
    apb(1'b1, `PSC_OFS, 32'h0000_0001);
    core_model_i.data_write(16'h0210, 8'hA5, 8'h05, n, im, ie);
    check(32'(n), 32'(PROG_CYC), "program stall");
    check(32'(im), 32'h0000_0000, "irq held");
    check(32'(ie), 32'h0000_0005, "irq released");
    op(16'h0210, 8'h3C, PROG_CYC);
    flash_is(1'b0, 16'h0210, 8'h24);
    check(32'(wr_seen), 32'h0000_0001, "ram writes");
    $display("test program done");
    apb(1'b1, `FMC_OFS, 32'h0000_0000);
    dbg_op(1'b0, 16'h0211, 8'h81);
    check(32'(done_seen), 32'h0000_0001, "debug done");
    flash_is(1'b0, 16'h0211, 8'h81);
    dbg_op(1'b1, 16'h0300, 8'h00);
    check(32'(done_seen), 32'h0000_0002, "debug erase done");
    flash_is(1'b0, 16'h0211, 8'hFF);
    $display("test debug done");
    apb(1'b1, `FMC_OFS, 32'h0000_0001);
    apb(1'b1, `PSC_OFS, 32'h0000_0003);
    op(16'h0010, 8'h00, ERASE_CYC);
    apb(1'b1, `PSC_OFS, 32'h0000_0007);
    op(16'h0010, 8'h00, ERASE_CYC);
    apb(1'b1, `PSC_OFS, 32'h0000_0005);
    op(16'h0010, 8'h5A, PROG_CYC);
    flash_is(1'b0, 16'h0010, 8'h5A);
    flash_is(1'b1, 16'h0010, 8'hFF);
    flash_is(1'b0, 16'h0090, 8'hFF);
    apb(1'b1, `PSC_OFS, 32'h0000_0000);
    flash_is(1'b0, 16'h0010, 8'hFF);
    $display("test scratchpad done");
    give_verdict();
  end

  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule : flash_program_erase_control_tb
